// ===== core/hpc_pkg.sv
// constants, encodings and state types shared by both ends of the host port link
// assumes one system clock on both ends and pins sampled synchronously to it
package hpc_pkg;

  localparam int HW = 16;
  localparam int DW = 32;
  localparam int AW = 32;
  localparam int FIFO_DEPTH = 8;

  // access type decode of {sel_a, sel_b}
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_DATA_INC = 2'h1;
  localparam logic [1:0] SEL_ADDR = 2'h2;
  localparam logic [1:0] SEL_DATA_FIX = 2'h3;
  localparam logic HALF_FIRST = 1'h0;

  // control register
  localparam int CTRL_READ_AHEAD_BIT = 0;
  localparam logic [HW-1:0] CTRL_RESET = 16'h0000;

  // timing; the device bus clock period is taken equal to the system clock period
  localparam int CLK_NS = 20;
  localparam int GAP_PERIODS = 2;
  localparam int GAP_CYC = GAP_PERIODS;
  localparam int STB_MIN_NS = 15;
  localparam int STB_MIN_CYC = (STB_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int DECIDE_CYC = (STB_MIN_CYC > 2) ? STB_MIN_CYC : 2;
  localparam int ADDR_SETTLE_CYC = 2;
  localparam int CNT_W = 3;
  localparam logic [AW-1:0] ADDR_STEP = 32'h0000_0004;
  localparam logic [HW-1:0] BUS_IDLE = 16'hffff;

  typedef enum logic [2:0] {
    DS_IDLE = 3'h1,
    DS_WAIT = 3'h2,
    DS_READY = 3'h4
  } hpc_dev_st_t;

  typedef enum logic [4:0] {
    HS_IDLE = 5'h01,
    HS_SETUP = 5'h02,
    HS_STROBE = 5'h04,
    HS_HOLD = 5'h08,
    HS_GAP = 5'h10
  } hpc_host_st_t;

endpackage

// ===== core/hpc_link_if.sv
// pin-level link between the external host and the device port
// assumes each end drives only its own enables; the shared bus floats high when idle
interface hpc_link_if;
  logic port_chip_select_n;
  logic data_strobe_one_n;
  logic data_strobe_two_n;
  logic access_type_sel_a;
  logic access_type_sel_b;
  logic port_read_not_write;
  logic halfword_order_sel;
  logic port_wait_n;
  logic [hpc_pkg::HW-1:0] host_bus_out;
  logic host_bus_oe;
  logic [hpc_pkg::HW-1:0] dev_bus_out;
  logic dev_bus_oe;
  logic [hpc_pkg::HW-1:0] port_shared_bus;

  assign port_shared_bus = dev_bus_oe ? dev_bus_out : (host_bus_oe ? host_bus_out : hpc_pkg::BUS_IDLE);

  modport dev (
    input port_chip_select_n, data_strobe_one_n, data_strobe_two_n,
    input access_type_sel_a, access_type_sel_b, port_read_not_write, halfword_order_sel,
    input port_shared_bus,
    output port_wait_n, dev_bus_out, dev_bus_oe
  );

  modport host (
    output port_chip_select_n, data_strobe_one_n, data_strobe_two_n,
    output access_type_sel_a, access_type_sel_b, port_read_not_write, halfword_order_sel,
    output host_bus_out, host_bus_oe,
    input port_shared_bus, port_wait_n
  );
endinterface

// ===== core/hpc_fifo.sv
// word fifo with valid/ready on both sides and a synchronous flush
// assumes the flush is not raised while the caller relies on a push in the same cycle
module hpc_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // control
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [PW:0] cnt_q, cnt_d;
  logic full_q, full_d, empty_q, empty_d;
  logic push, pop;

  assign push = in_valid && !full_q;
  assign pop = out_ready && !empty_q;
  assign in_ready = !full_q;
  assign out_valid = !empty_q;
  assign out_data = mem[rp_q];

  always_comb begin
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    if (push) wp_d = (wp_q == PW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
    if (pop) rp_d = (rp_q == PW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
    if (flush) begin
      wp_d = '0;
      rp_d = '0;
      cnt_d = '0;
    end
    full_d = (cnt_d == (PW+1)'(DEPTH));
    empty_d = (cnt_d == '0);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      full_q <= 1'b0;
      empty_q <= 1'b1;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      full_q <= full_d;
      empty_q <= empty_d;
    end
  end

  // storage has no reset: contents are only read behind the empty flag
  always_ff @(posedge clk_sys) begin
    if (push && !flush) mem[wp_q] <= in_data;
  end
endmodule

// ===== core/hpc_port_dev.sv
// device end of the host port: strobe decode, wait generation, word fifos, address register
// assumes link pins synchronous to clk_sys; memory side answers reads one word at a time
// Contract
// - strobe is chip select OR NOT(strobe XOR)
// - host holds strobe until wait goes low
// - writes stall on four listed conditions only
// - reads stall on missing fifo or fixed first
// - other reads never stall
// - selects sampled at strobe falling edge
// - write data captured at strobe rising edge
// - host keeps strobe high two clock periods
// - bus driven only while read strobe low; the registered enable drops one clock after the strobe rises
// - chip select high forces wait low
// - eight word read and write fifos
// - auto-increment advances address per data word
module hpc_port_dev #(
  parameter int DEPTH = hpc_pkg::FIFO_DEPTH,
  parameter int AW = hpc_pkg::AW
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // host link
  hpc_link_if.dev link,
  // memory write side
  output logic mem_wr_valid,
  input wire logic mem_wr_ready,
  output logic [AW-1:0] mem_wr_addr,
  output logic [hpc_pkg::DW-1:0] mem_wr_data,
  // memory read side
  output logic mem_rd_req_valid,
  input wire logic mem_rd_req_ready,
  output logic [AW-1:0] mem_rd_req_addr,
  input wire logic mem_rd_rsp_valid,
  output logic mem_rd_rsp_ready,
  input wire logic [hpc_pkg::DW-1:0] mem_rd_rsp_data,
  // status
  output logic [hpc_pkg::HW-1:0] ctrl_value
);
  localparam int HW = hpc_pkg::HW;
  localparam int DW = hpc_pkg::DW;

  hpc_pkg::hpc_dev_st_t state_q, state_d;
  logic strobe_n, strb_q, fall, rise;
  logic [1:0] sel_q, sel_d, cur_sel;
  logic rnw_q, rnw_d, half_q, half_d, cur_rnw, cur_half;
  logic wait_n_q, wait_n_d, oe_q, oe_d;
  logic [HW-1:0] dout_q, dout_d, ctrl_q, ctrl_d, wlo_q, wlo_d;
  logic [AW-1:0] addr_q, addr_d, req_addr_q, req_addr_d;
  logic [DW-1:0] rword_q, rword_d;
  logic last_addr_q, last_addr_d, ahead_q, ahead_d;
  logic pend_q, pend_d, req_q, req_d;
  logic [hpc_pkg::CNT_W-1:0] settle_q, settle_d;
  logic busy, done, act, want_fetch;
  logic wf_push, wf_ready, wf_valid, rf_valid, rf_pop, rf_flush;
  logic [AW+DW-1:0] wf_in, wf_out;
  logic [DW-1:0] rf_out;

  assign strobe_n = link.port_chip_select_n | ~(link.data_strobe_one_n ^ link.data_strobe_two_n);
  assign fall = strb_q && !strobe_n;
  assign rise = !strb_q && strobe_n;
  // selects come straight from the pins at the falling edge, from the latch afterwards
  assign cur_sel = fall ? {link.access_type_sel_a, link.access_type_sel_b} : sel_q;
  assign cur_rnw = fall ? link.port_read_not_write : rnw_q;
  assign cur_half = fall ? link.halfword_order_sel : half_q;

  ////////////////////////////////////////////////////////////////////////
  // buffering

  hpc_fifo #(.W(AW+DW), .DEPTH(DEPTH)) u_wr_fifo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .flush(1'b0),
    .in_valid(wf_push),
    .in_ready(wf_ready),
    .in_data(wf_in),
    .out_valid(wf_valid),
    .out_ready(mem_wr_ready),
    .out_data(wf_out)
  );

  hpc_fifo #(.W(DW), .DEPTH(DEPTH)) u_rd_fifo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .flush(rf_flush),
    .in_valid(mem_rd_rsp_valid),
    .in_ready(mem_rd_rsp_ready),
    .in_data(mem_rd_rsp_data),
    .out_valid(rf_valid),
    .out_ready(rf_pop),
    .out_data(rf_out)
  );

  assign mem_wr_valid = wf_valid;
  assign mem_wr_addr = wf_out[AW+DW-1:DW];
  assign mem_wr_data = wf_out[DW-1:0];
  assign mem_rd_req_valid = req_q;
  assign mem_rd_req_addr = req_addr_q;
  assign ctrl_value = ctrl_q;
  assign link.port_wait_n = wait_n_q;
  assign link.dev_bus_out = dout_q;
  assign link.dev_bus_oe = oe_q;

  ////////////////////////////////////////////////////////////////////////
  // stall decision

  always_comb begin
    busy = 1'b0;
    done = 1'b1;
    case (cur_sel)
      hpc_pkg::SEL_ADDR: begin
        if (!cur_rnw) begin
          // back-to-back address, address after read-ahead, or writes still draining
          busy = (last_addr_q && cur_half == hpc_pkg::HALF_FIRST) || ahead_q || wf_valid;
          done = (settle_q == '0) && !wf_valid && !pend_q;
        end
      end
      hpc_pkg::SEL_DATA_INC, hpc_pkg::SEL_DATA_FIX: begin
        if (!cur_rnw) begin
          busy = !wf_ready && cur_half != hpc_pkg::HALF_FIRST;
          done = wf_ready;
        end else if (cur_half == hpc_pkg::HALF_FIRST) begin
          busy = (cur_sel == hpc_pkg::SEL_DATA_FIX) || !rf_valid;
          done = rf_valid && !pend_q;
        end
      end
      default: begin
        busy = 1'b0;
      end
    endcase
  end

  assign act = (fall && !busy) || (state_q == hpc_pkg::DS_WAIT && done && !rise && !fall);
  assign want_fetch = !pend_q && !req_q && !rf_valid;

  ////////////////////////////////////////////////////////////////////////
  // access sequencing

  always_comb begin
    state_d = state_q;
    sel_d = sel_q;
    rnw_d = rnw_q;
    half_d = half_q;
    dout_d = dout_q;
    ctrl_d = ctrl_q;
    wlo_d = wlo_q;
    addr_d = addr_q;
    rword_d = rword_q;
    last_addr_d = last_addr_q;
    ahead_d = ahead_q;
    pend_d = pend_q;
    req_d = req_q;
    req_addr_d = req_addr_q;
    settle_d = (settle_q != '0) ? settle_q - 1'b1 : settle_q;
    rf_pop = 1'b0;
    rf_flush = 1'b0;
    wf_push = 1'b0;
    wf_in = {addr_q, link.port_shared_bus, wlo_q};
    if (req_q && mem_rd_req_ready) req_d = 1'b0;
    if (mem_rd_rsp_valid && mem_rd_rsp_ready) pend_d = 1'b0;
    if (fall) begin
      sel_d = cur_sel;
      rnw_d = cur_rnw;
      half_d = cur_half;
      state_d = busy ? hpc_pkg::DS_WAIT : hpc_pkg::DS_READY;
      if (busy && cur_sel == hpc_pkg::SEL_ADDR) settle_d = hpc_pkg::CNT_W'(hpc_pkg::ADDR_SETTLE_CYC);
      // a fixed read always refetches; a fetch still in flight may land after this flush
      if (busy && cur_rnw && cur_sel == hpc_pkg::SEL_DATA_FIX) rf_flush = 1'b1;
    end
    if (state_q == hpc_pkg::DS_WAIT && rnw_q && (sel_q == hpc_pkg::SEL_DATA_INC || sel_q == hpc_pkg::SEL_DATA_FIX)
        && want_fetch) begin
      req_d = 1'b1;
      req_addr_d = addr_q;
      pend_d = 1'b1;
    end
    if (act) begin
      state_d = hpc_pkg::DS_READY;
      if (cur_rnw) begin
        last_addr_d = 1'b0;
        case (cur_sel)
          hpc_pkg::SEL_CTRL: dout_d = ctrl_q;
          hpc_pkg::SEL_ADDR: dout_d = (cur_half == hpc_pkg::HALF_FIRST) ? addr_q[HW-1:0] : addr_q[2*HW-1:HW];
          default: begin
            ahead_d = 1'b0;
            if (cur_half == hpc_pkg::HALF_FIRST) begin
              dout_d = rf_out[HW-1:0];
              rword_d = rf_out;
              rf_pop = 1'b1;
            end else begin
              dout_d = rword_q[DW-1:HW];
              if (cur_sel == hpc_pkg::SEL_DATA_INC) addr_d = addr_q + hpc_pkg::ADDR_STEP;
            end
          end
        endcase
      end
    end
    if (rise) begin
      state_d = hpc_pkg::DS_IDLE;
      // a write only lands if the wait was honoured
      if (state_q == hpc_pkg::DS_READY && !rnw_q) begin
        case (sel_q)
          hpc_pkg::SEL_CTRL: begin
            ctrl_d = link.port_shared_bus;
            ctrl_d[hpc_pkg::CTRL_READ_AHEAD_BIT] = 1'b0;
            last_addr_d = 1'b0;
            if (link.port_shared_bus[hpc_pkg::CTRL_READ_AHEAD_BIT] && want_fetch) begin
              ahead_d = 1'b1;
              req_d = 1'b1;
              req_addr_d = addr_q;
              pend_d = 1'b1;
            end
          end
          hpc_pkg::SEL_ADDR: begin
            if (half_q == hpc_pkg::HALF_FIRST) addr_d[HW-1:0] = link.port_shared_bus;
            else addr_d[2*HW-1:HW] = link.port_shared_bus;
            last_addr_d = 1'b1;
            ahead_d = 1'b0;
            rf_flush = 1'b1;
          end
          default: begin
            last_addr_d = 1'b0;
            ahead_d = 1'b0;
            if (half_q == hpc_pkg::HALF_FIRST) begin
              wlo_d = link.port_shared_bus;
            end else begin
              wf_push = 1'b1;
              if (sel_q == hpc_pkg::SEL_DATA_INC) addr_d = addr_q + hpc_pkg::ADDR_STEP;
            end
          end
        endcase
      end
    end
    oe_d = !strobe_n && (fall ? cur_rnw : (oe_q && rnw_q));
    wait_n_d = link.port_chip_select_n ? 1'b0 : (state_d == hpc_pkg::DS_WAIT);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= hpc_pkg::DS_IDLE;
      strb_q <= 1'b1;
      sel_q <= hpc_pkg::SEL_CTRL;
      rnw_q <= 1'b1;
      half_q <= hpc_pkg::HALF_FIRST;
      wait_n_q <= 1'b0;
      oe_q <= 1'b0;
      dout_q <= '0;
      ctrl_q <= hpc_pkg::CTRL_RESET;
      wlo_q <= '0;
      addr_q <= '0;
      rword_q <= '0;
      last_addr_q <= 1'b0;
      ahead_q <= 1'b0;
      pend_q <= 1'b0;
      req_q <= 1'b0;
      req_addr_q <= '0;
      settle_q <= '0;
    end else begin
      state_q <= state_d;
      strb_q <= strobe_n;
      sel_q <= sel_d;
      rnw_q <= rnw_d;
      half_q <= half_d;
      wait_n_q <= wait_n_d;
      oe_q <= oe_d;
      dout_q <= dout_d;
      ctrl_q <= ctrl_d;
      wlo_q <= wlo_d;
      addr_q <= addr_d;
      rword_q <= rword_d;
      last_addr_q <= last_addr_d;
      ahead_q <= ahead_d;
      pend_q <= pend_d;
      req_q <= req_d;
      req_addr_q <= req_addr_d;
      settle_q <= settle_d;
    end
  end
endmodule

// ===== core/hpc_port_host.sv
// host end: turns one half-word command into a full strobe cycle on the link
// assumes the device answers on the same clk_sys; no timeout on a stuck wait
module hpc_port_host (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // host link
  hpc_link_if.host link,
  // command side
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [1:0] cmd_sel,
  input wire logic cmd_half,
  input wire logic [hpc_pkg::HW-1:0] cmd_wdata,
  // answer side
  output logic rsp_valid,
  output logic [hpc_pkg::HW-1:0] rsp_rdata
);
  hpc_pkg::hpc_host_st_t state_q, state_d;
  logic [hpc_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [1:0] sel_q, sel_d;
  logic wr_q, wr_d, half_q, half_d, cs_n_q, cs_n_d, ds_n_q, ds_n_d, oe_q, oe_d, rv_q, rv_d;
  logic [hpc_pkg::HW-1:0] wd_q, wd_d, rd_q, rd_d;

  assign cmd_ready = (state_q == hpc_pkg::HS_IDLE);
  assign link.port_chip_select_n = cs_n_q;
  assign link.data_strobe_one_n = ds_n_q;
  assign link.data_strobe_two_n = 1'b1;
  assign link.access_type_sel_a = sel_q[1];
  assign link.access_type_sel_b = sel_q[0];
  assign link.port_read_not_write = !wr_q;
  assign link.halfword_order_sel = half_q;
  assign link.host_bus_out = wd_q;
  assign link.host_bus_oe = oe_q;
  assign rsp_valid = rv_q;
  assign rsp_rdata = rd_q;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q + 1'b1;
    sel_d = sel_q;
    wr_d = wr_q;
    half_d = half_q;
    wd_d = wd_q;
    cs_n_d = cs_n_q;
    ds_n_d = ds_n_q;
    oe_d = oe_q;
    rd_d = rd_q;
    rv_d = 1'b0;
    case (state_q)
      hpc_pkg::HS_IDLE: begin
        if (cmd_valid) begin
          // selects and data go out a cycle ahead of the strobe
          state_d = hpc_pkg::HS_SETUP;
          sel_d = cmd_sel;
          wr_d = cmd_write;
          half_d = cmd_half;
          wd_d = cmd_wdata;
          oe_d = cmd_write;
          cs_n_d = 1'b0;
        end
      end
      hpc_pkg::HS_SETUP: begin
        state_d = hpc_pkg::HS_STROBE;
        ds_n_d = 1'b0;
        cnt_d = '0;
      end
      hpc_pkg::HS_STROBE: begin
        // wait is only trusted once the device has had time to decode
        if (cnt_q >= hpc_pkg::CNT_W'(hpc_pkg::DECIDE_CYC - 1) && !link.port_wait_n) begin
          state_d = hpc_pkg::HS_HOLD;
          ds_n_d = 1'b1;
          if (!wr_q) begin
            rd_d = link.port_shared_bus;
            rv_d = 1'b1;
          end
        end
        if (cnt_q == {hpc_pkg::CNT_W{1'b1}}) cnt_d = cnt_q;
      end
      hpc_pkg::HS_HOLD: begin
        // data stays on the bus through the edge where the device captures it
        state_d = hpc_pkg::HS_GAP;
        oe_d = 1'b0;
        cs_n_d = 1'b1;
        cnt_d = '0;
        if (wr_q) rv_d = 1'b1;
      end
      hpc_pkg::HS_GAP: begin
        if (cnt_q >= hpc_pkg::CNT_W'(hpc_pkg::GAP_CYC - 2)) state_d = hpc_pkg::HS_IDLE;
      end
      default: state_d = hpc_pkg::HS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= hpc_pkg::HS_IDLE;
      cnt_q <= '0;
      sel_q <= hpc_pkg::SEL_CTRL;
      wr_q <= 1'b0;
      half_q <= hpc_pkg::HALF_FIRST;
      wd_q <= '0;
      cs_n_q <= 1'b1;
      ds_n_q <= 1'b1;
      oe_q <= 1'b0;
      rd_q <= '0;
      rv_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sel_q <= sel_d;
      wr_q <= wr_d;
      half_q <= half_d;
      wd_q <= wd_d;
      cs_n_q <= cs_n_d;
      ds_n_q <= ds_n_d;
      oe_q <= oe_d;
      rd_q <= rd_d;
      rv_q <= rv_d;
    end
  end
endmodule

// ===== tb/hpc_link_assertions.sv
// link checker: strobe, wait, select and bus-drive relations on the host port pins
// assumes it sits beside the link interface, one clock domain
module hpc_link_assertions (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // host side
  input wire logic port_chip_select_n,
  input wire logic data_strobe_one_n,
  input wire logic data_strobe_two_n,
  input wire logic access_type_sel_a,
  input wire logic access_type_sel_b,
  input wire logic port_read_not_write,
  input wire logic halfword_order_sel,
  input wire logic [hpc_pkg::HW-1:0] host_bus_out,
  input wire logic host_bus_oe,
  // device side
  input wire logic port_wait_n,
  input wire logic dev_bus_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic stb_n;
  logic rd_act;
  logic calm;
  logic [1:0] sel;
  assign stb_n = port_chip_select_n | ~(data_strobe_one_n ^ data_strobe_two_n);
  assign rd_act = ~stb_n & port_read_not_write;
  assign sel = {access_type_sel_a, access_type_sel_b};
  // accesses that must never see wait
  assign calm = (sel == hpc_pkg::SEL_CTRL) || (port_read_not_write && (sel == hpc_pkg::SEL_ADDR ||
    halfword_order_sel != hpc_pkg::HALF_FIRST)) || (!port_read_not_write && sel != hpc_pkg::SEL_ADDR &&
    halfword_order_sel == hpc_pkg::HALF_FIRST);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  sequence s_fall;
    $fell(stb_n);
  endsequence
  sequence s_sel_held;
    $stable(sel) && $stable(port_read_not_write) && $stable(halfword_order_sel);
  endsequence
  property p_sel_stable;
    s_fall |-> s_sel_held ##1 s_sel_held;
  endproperty
  property p_no_stall;
    s_fall ##0 calm |-> !port_wait_n [*4];
  endproperty
  property p_fix_stall;
    s_fall ##0 (rd_act && sel == hpc_pkg::SEL_DATA_FIX && halfword_order_sel == hpc_pkg::HALF_FIRST)
      |-> ##[1:4] port_wait_n;
  endproperty
  property p_oe_read;
    dev_bus_oe |-> $past(rd_act) || $past(rd_act, 2);
  endproperty
  property p_one_driver;
    !(dev_bus_oe && host_bus_oe);
  endproperty
  property p_cs_ready;
    port_chip_select_n [*3] |-> !port_wait_n;
  endproperty
  property p_hold_stb;
    !stb_n && port_wait_n |=> !stb_n;
  endproperty
  property p_gap;
    $rose(stb_n) |=> stb_n;
  endproperty
  property p_wdata_hold;
    $rose(stb_n) && !port_read_not_write |-> host_bus_oe && $stable(host_bus_out);
  endproperty
  property p_wait_cause;
    $rose(port_wait_n) |-> !$past(stb_n) || !$past(stb_n, 2);
  endproperty
  a_sel_stable: assert property (p_sel_stable) else $error("selects moved at strobe fall");
  a_no_stall: assert property (p_no_stall) else $error("wait raised on a no-wait access");
  a_fix_stall: assert property (p_fix_stall) else $error("fixed read first half did not wait");
  a_oe_read: assert property (p_oe_read) else $error("device drove bus outside a read");
  a_one_driver: assert property (p_one_driver) else $error("both ends drive the bus");
  a_cs_ready: assert property (p_cs_ready) else $error("wait high while deselected");
  a_hold_stb: assert property (p_hold_stb) else $error("strobe released during wait");
  a_gap: assert property (p_gap) else $error("strobe high gap too short");
  a_wdata_hold: assert property (p_wdata_hold) else $error("write data not held at strobe rise");
  a_wait_cause: assert property (p_wait_cause) else $error("wait rose without strobe");
endmodule

// ===== tb/tb_host_port_cycle_handshake.sv
// bench: host end and device end joined by the link; memory side played here
// assumes one 50 MHz clock; read data of word address a is {~a[15:0], a[15:0]}
module tb_host_port_cycle_handshake;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rstn, mem_wr_valid, mem_wr_ready, mem_rd_req_valid, mem_rd_rsp_valid, mem_rd_rsp_ready;
  logic [31:0] mem_wr_addr, mem_wr_data, mem_rd_req_addr, mem_rd_rsp_data;
  logic cmd_valid, cmd_ready, cmd_write, cmd_half, rsp_valid;
  logic [1:0] cmd_sel;
  logic [15:0] cmd_wdata, rsp_rdata, ctrl_value;
  logic [63:0] wq [$];
  int error_cnt = 0, n_compared = 0, stall_cyc = 0, rd_lat = 0;
  hpc_link_if link ();
  hpc_port_dev u_hpc_port_dev (.clk_sys(clk_sys), .rstn(rstn), .link(link), .mem_wr_valid(mem_wr_valid),
    .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .mem_rd_req_valid(mem_rd_req_valid), .mem_rd_req_ready(1'h1), .mem_rd_req_addr(mem_rd_req_addr),
    .mem_rd_rsp_valid(mem_rd_rsp_valid), .mem_rd_rsp_ready(mem_rd_rsp_ready),
    .mem_rd_rsp_data(mem_rd_rsp_data), .ctrl_value(ctrl_value));
  hpc_port_host u_hpc_port_host (.clk_sys(clk_sys), .rstn(rstn), .link(link), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_sel(cmd_sel), .cmd_half(cmd_half),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  hpc_link_assertions u_hpc_link_assertions (.clk_sys(clk_sys), .rstn(rstn),
    .port_chip_select_n(link.port_chip_select_n), .data_strobe_one_n(link.data_strobe_one_n),
    .data_strobe_two_n(link.data_strobe_two_n), .access_type_sel_a(link.access_type_sel_a),
    .access_type_sel_b(link.access_type_sel_b), .port_read_not_write(link.port_read_not_write),
    .halfword_order_sel(link.halfword_order_sel), .host_bus_out(link.host_bus_out),
    .host_bus_oe(link.host_bus_oe), .port_wait_n(link.port_wait_n), .dev_bus_oe(link.dev_bus_oe));
  ////////////////////////////////////////
  initial begin
    clk_sys = 1'h0;
    forever #(hpc_pkg::CLK_NS / 2) clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (link.port_wait_n === 1'b1) stall_cyc++;
    if (mem_wr_valid === 1'b1 && mem_wr_ready === 1'b1) wq.push_back({mem_wr_addr, mem_wr_data});
  end
  // one outstanding read; released data flips so stale values never match
  initial begin
    logic [31:0] a;
    forever begin
      if (mem_rd_req_valid === 1'b1) begin
        a = mem_rd_req_addr;
        repeat (rd_lat + 1) @(posedge clk_sys);
        #1;
        mem_rd_rsp_data = {~a[15:0], a[15:0]};
        mem_rd_rsp_valid = 1'h1;
        do @(posedge clk_sys);
        while (mem_rd_rsp_ready !== 1'b1);
        #1;
        mem_rd_rsp_valid = 1'h0;
        mem_rd_rsp_data = ~mem_rd_rsp_data;
      end else begin
        @(posedge clk_sys);
        #1;
      end
    end
  end
  ////////////////////////////////////////
  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic op(logic w, logic [1:0] s, logic h, logic [15:0] wd, output logic [15:0] rd);
    int n = 0;
    {cmd_write, cmd_sel, cmd_half, cmd_wdata, cmd_valid} = {w, s, h, wd, 1'h1};
    while (cmd_ready !== 1'b1 && n < 900) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    @(posedge clk_sys);
    #1;
    cmd_valid = 1'h0;
    while (rsp_valid !== 1'b1 && n < 900) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    check("answer", n < 900, 1'b1);
    rd = rsp_rdata;
  endtask
  task automatic wr16(logic [1:0] s, logic h, logic [15:0] d);
    logic [15:0] r;
    op(1'h1, s, h, d, r);
  endtask
  task automatic rd16(logic [1:0] s, logic h, output logic [15:0] r);
    op(1'h0, s, h, 16'h0000, r);
  endtask
  task automatic wr32(logic [1:0] s, logic [31:0] d);
    wr16(s, hpc_pkg::HALF_FIRST, d[15:0]);
    wr16(s, !hpc_pkg::HALF_FIRST, d[31:16]);
  endtask
  task automatic rd32(logic [1:0] s, output logic [31:0] d);
    rd16(s, hpc_pkg::HALF_FIRST, d[15:0]);
    rd16(s, !hpc_pkg::HALF_FIRST, d[31:16]);
  endtask
  task automatic wait_wq(int n);
    for (int k = 0; k < 900 && wq.size() < n; k++) @(posedge clk_sys);
    #1;
    check("write count", wq.size(), n);
  endtask
  task automatic release_after(int n);
    fork
      begin
        repeat (n) @(posedge clk_sys);
        #1;
        mem_wr_ready = 1'h1;
      end
    join_none
  endtask
  ////////////////////////////////////////
  task automatic t_ctrl_addr();
    logic [31:0] r;
    int s;
    wr16(hpc_pkg::SEL_CTRL, hpc_pkg::HALF_FIRST, 16'h5a5e);
    rd16(hpc_pkg::SEL_CTRL, hpc_pkg::HALF_FIRST, r[15:0]);
    check("ctrl read", r[15:0], 16'h5a5e);
    check("ctrl port", ctrl_value, 16'h5a5e);
    wr32(hpc_pkg::SEL_ADDR, 32'h0000_0100);
    s = stall_cyc;
    wr32(hpc_pkg::SEL_ADDR, 32'h0000_0200);
    check("addr rewrite wait", stall_cyc > s, 1'b1);
    s = stall_cyc;
    rd32(hpc_pkg::SEL_ADDR, r);
    check("addr read", r, 32'h0000_0200);
    check("addr read wait", stall_cyc == s, 1'b1);
    $display("test ctrl_addr done");
  endtask
  task automatic t_write();
    logic [15:0] r;
    int s;
    wq.delete();
    wr32(hpc_pkg::SEL_ADDR, 32'h0000_1000);
    wr32(hpc_pkg::SEL_DATA_INC, 32'h1111_2222);
    wr32(hpc_pkg::SEL_DATA_INC, 32'h3333_4444);
    wait_wq(2);
    check("inc word 0", wq[0], 64'h0000_1000_1111_2222);
    check("inc word 1", wq[1], 64'h0000_1004_3333_4444);
    rd16(hpc_pkg::SEL_ADDR, hpc_pkg::HALF_FIRST, r);
    check("addr after inc", r, 16'h1008);
    wq.delete();
    mem_wr_ready = 1'h0;
    wr32(hpc_pkg::SEL_ADDR, 32'h0000_2000);
    release_after(300);
    s = stall_cyc;
    for (int i = 0; i < hpc_pkg::FIFO_DEPTH + 2; i++) wr32(hpc_pkg::SEL_DATA_FIX, 32'h0a0a_0000 + 32'(i));
    check("full wait", stall_cyc > s, 1'b1);
    wait_wq(hpc_pkg::FIFO_DEPTH + 2);
    for (int i = 0; i < hpc_pkg::FIFO_DEPTH + 2; i++)
      check("fix word", wq[i], {32'h2000, 32'h0a0a_0000 + 32'(i)});
    mem_wr_ready = 1'h0;
    wr32(hpc_pkg::SEL_DATA_FIX, 32'h0b0b_0000);
    release_after(80);
    s = stall_cyc;
    wr32(hpc_pkg::SEL_ADDR, 32'h0000_3000);
    check("busy addr wait", stall_cyc - s > 40, 1'b1);
    $display("test write done");
  endtask
  task automatic t_read();
    logic [31:0] r;
    int s;
    wr16(hpc_pkg::SEL_CTRL, hpc_pkg::HALF_FIRST, 16'h0001);
    s = stall_cyc;
    rd32(hpc_pkg::SEL_DATA_INC, r);
    check("inc read 0", {r, stall_cyc == s}, {32'hcfff_3000, 1'b1});
    rd32(hpc_pkg::SEL_DATA_INC, r);
    check("inc read 1", r, 32'hcffb_3004);
    wr32(hpc_pkg::SEL_ADDR, 32'h0000_4000);
    s = stall_cyc;
    rd32(hpc_pkg::SEL_DATA_FIX, r);
    check("fix read wait", stall_cyc > s, 1'b1);
    rd32(hpc_pkg::SEL_DATA_FIX, r);
    check("fix read", r, 32'hbfff_4000);
    rd32(hpc_pkg::SEL_ADDR, r);
    check("fix addr", r, 32'h0000_4000);
    rd_lat = 40;
    wr16(hpc_pkg::SEL_CTRL, hpc_pkg::HALF_FIRST, 16'h0001);
    s = stall_cyc;
    wr32(hpc_pkg::SEL_ADDR, 32'h0000_5000);
    check("read-ahead addr wait", stall_cyc > s, 1'b1);
    $display("test read done");
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    {rstn, cmd_valid, cmd_write, cmd_sel, cmd_half, cmd_wdata} = '0;
    {mem_wr_ready, mem_rd_rsp_valid, mem_rd_rsp_data} = {1'h1, 1'h0, 32'h0};
    repeat (16) @(posedge clk_sys);
    #1;
    rstn = 1'h1;
    t_ctrl_addr();
    t_write();
    t_read();
    give_verdict();
  end
  // tests take about 750 cycles
  initial begin
    repeat (6000) @(posedge clk_sys);
    error_cnt++;
    give_verdict();
  end
endmodule
